// [hdl/cit_map.vh]
`ifndef CIT_MAP_VH
`define CIT_MAP_VH

// Register word addresses on the Avalon-MM slave
`define CIT_REG_CTRL       10'h000
`define CIT_REG_MULT       10'h001
`define CIT_REG_ADDER      10'h002
`define CIT_REG_FLOOR      10'h003
`define CIT_REG_HCT_TIME   10'h004
`define CIT_REG_HIGH_CURRENT_MULTIPLE_THRESHOLD  10'h005
`define CIT_REG_BASE_CHAR  10'h006
`define CIT_REG_STATUS     10'h007
`define CIT_REG_LAST_TIME  10'h008

// Point table window: address bit that selects it, curve and index fields
`define CIT_PT_WIN_BIT     9
`define CIT_PT_CURVE_HI    8
`define CIT_PT_CURVE_LO    7
`define CIT_PT_IDX_HI      6

// Control register fields
`define CIT_CTRL_COMP      0
`define CIT_CTRL_FLOOR     1
`define CIT_CTRL_HCT       2
`define CIT_CTRL_CSEL_LO   4
`define CIT_CTRL_CSEL_HI   5

// Status register fields
`define CIT_STAT_BUSY      0
`define CIT_STAT_OPER      1
`define CIT_STAT_CLAMP     2

// Reset values
`define CIT_MULT_RST       16'h0100
`define CIT_ZERO16         16'h0000

// Point counts per curve (reset points first, then operate points)
`define CIT_PTS_RESET      7'h28
`define CIT_PTS_OPER       7'h50
`define CIT_PTS_CURVE      7'h78
`define CIT_LAST_RESET     7'h27
`define CIT_LAST_OPER      7'h4f

// Multiples in hundredths of pickup
`define CIT_ONE_PU         16'h0064
`define CIT_FIRST_OPER     12'h067
`define CIT_LAST_RESET_M   12'h062
`define CIT_LAST_OPER_M    12'h7d0

// Number of selectable base characteristics
`define CIT_BASE_COUNT     6'h29

// Multiplier fraction bits and divider steps
`define CIT_MULT_FRAC      8
`define CIT_DIV_STEPS      5'h16

`endif

// [hdl/cit_point_mem.v]
`timescale 1ns/1ps
`default_nettype none

// Single-port point store; read data come out of a register
module cit_point_mem #(
  parameter DW = 16,
  parameter AW = 9
) (
  input  wire          sys_clk,
  input  wire          mem_we,
  input  wire          mem_re,
  input  wire [AW-1:0] mem_addr,
  input  wire [DW-1:0] mem_wdata,
  output reg  [DW-1:0] mem_rdata
);

  reg [DW-1:0] store [0:(1<<AW)-1]; // Point times in milliseconds

  // Write or registered read, one per cycle
  always @(posedge sys_clk)
  begin
    if (mem_we)
    begin
      store[mem_addr] <= mem_wdata;
    end
    else if (mem_re)
    begin
      mem_rdata <= store[mem_addr];
    end
  end

endmodule
`default_nettype wire

// [hdl/cit_curve_top.v]
// Contract
// - Point times 0..65535 ms, 1 ms steps
// - Four curves: reset 0.00-0.98, operate 1.03-20.00
// - Linear interpolation between neighbouring stored points
// - Composite: multiply curve operating time
// - Composite: add adder milliseconds to curve time
// - Composite: enabled floor limits operating time from below
// - Composite: above threshold multiple, fixed high-current time
// - Multiplier, adder leave floor and fixed time
// - Fixed high-current time overrides the floor
// - Composite accepts one of 41 base characteristics
`include "cit_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cit_curve_top #(
  parameter TW = 16, // Point time width in ms
  parameter MW = 16  // Pickup multiple width, hundredths
) (
  input  wire          sys_clk,
  input  wire          rst_n,
  input  wire [9:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  input  wire [3:0]    avs_byteenable,
  output reg  [31:0]   avs_readdata,
  output reg           avs_waitrequest,
  input  wire          req_valid,
  input  wire [1:0]    req_curve,
  input  wire [MW-1:0] req_multiple,
  output reg           req_ready,
  output reg           resp_valid,
  output reg  [31:0]   resp_time,
  output reg           resp_operate
);

  // Bus states
  localparam BS_IDLE  = 2'b00;
  localparam BS_MEMRD = 2'b01;
  localparam BS_ACK   = 2'b10;
  // Engine states
  localparam ES_IDLE  = 3'b000;
  localparam ES_SCAN  = 3'b001;
  localparam ES_RD0   = 3'b010;
  localparam ES_RD1   = 3'b011;
  localparam ES_RD2   = 3'b100;
  localparam ES_RD3   = 3'b101;
  localparam ES_DIV   = 3'b110;
  localparam ES_OUT   = 3'b111;

  // Multiple of one stored point, in hundredths of pickup
  function [11:0] cit_point_mult;
    input       is_op;
    input [6:0] k;
    reg   [11:0] kk;
    begin
      kk = {5'h00, k};
      if (!is_op)
      begin
        if (k < 7'h0a)
          cit_point_mult = 12'h005 * kk;
        else if (k < 7'h14)
          cit_point_mult = 12'h030 + 12'h002 * (kk - 12'h00a);
        else if (k < 7'h20)
          cit_point_mult = 12'h044 + 12'h002 * (kk - 12'h014);
        else
          cit_point_mult = 12'h05b + (kk - 12'h020);
      end
      else
      begin
        if (k == 7'h00)
          cit_point_mult = `CIT_FIRST_OPER;
        else if (k == 7'h01)
          cit_point_mult = 12'h069;
        else if (k < 7'h34)
          cit_point_mult = 12'h06e + 12'h00a * (kk - 12'h002);
        else
          cit_point_mult = 12'h28a + 12'h032 * (kk - 12'h034);
      end
    end
  endfunction

  // Memory address of point k of a curve
  function [8:0] cit_mem_addr;
    input [1:0] curve;
    input       is_op;
    input [6:0] k;
    begin
      cit_mem_addr = {curve, is_op ? (k + `CIT_PTS_RESET) : k};
    end
  endfunction

  // Settings registers
  reg  [15:0] ctrl_reg;       // Enables and composite curve select
  reg  [15:0] mult_reg;       // Multiplier, 8.8 fixed point
  reg  [15:0] adder_reg;      // Adder in ms
  reg  [15:0] min_response_floor_reg;
  reg  [15:0] high_current_fixed_time_reg;
  reg  [15:0] high_current_multiple_threshold_reg;
  reg  [5:0]  base_char_reg;  // Selected base characteristic
  reg  [31:0] last_time_reg;  // Last answered time
  reg         last_clamp_reg; // Last request held at a table end

  // Bus side
  reg  [1:0]  bs_reg;
  wire        bus_req   = avs_read | avs_write;
  wire        bus_pt    = avs_address[`CIT_PT_WIN_BIT];
  wire        pt_ok     = avs_address[`CIT_PT_IDX_HI:0] < `CIT_PTS_CURVE;
  wire        bus_mem_rd = (bs_reg == BS_IDLE) & avs_read & bus_pt & pt_ok;
  wire        bus_mem_wr = (bs_reg == BS_ACK) & avs_write & bus_pt & pt_ok
                           & (avs_byteenable[1:0] == 2'b11);
  wire        bus_mem   = bus_mem_rd | bus_mem_wr;
  wire        reg_wr    = (bs_reg == BS_ACK) & avs_write & ~bus_pt;
  reg  [31:0] reg_rdata;

  // Engine side
  reg  [2:0]  es_reg;
  reg  [1:0]  e_curve;
  reg  [MW-1:0] e_raw;
  reg  [11:0] e_m;
  reg         e_op;
  reg  [6:0]  e_idx;
  reg  [15:0] e_t0;
  reg  [21:0] e_q;
  reg  [5:0]  e_rem;
  reg  [5:0]  e_den;
  reg         e_neg;
  reg  [4:0]  e_cnt;
  reg  [TW-1:0] e_ct;
  wire [6:0]  e_last = e_op ? `CIT_LAST_OPER : `CIT_LAST_RESET;
  wire [6:0]  e_nxt  = (e_idx == e_last) ? e_idx : e_idx + 7'h01;
  wire        e_mem_rd = ((es_reg == ES_RD0) | (es_reg == ES_RD2))
                         & ~bus_mem;
  wire [11:0] m_lo = cit_point_mult(e_op, e_idx);
  wire [11:0] m_hi = cit_point_mult(e_op, e_nxt);
  wire [6:0]  trial = {e_rem, e_q[21]};

  // Shared point store port; the bus wins a clash and the engine retries
  wire [8:0]  mem_addr = bus_mem ? avs_address[8:0]
                       : cit_mem_addr(e_curve, e_op,
                           (es_reg == ES_RD2) ? e_nxt : e_idx);
  wire [15:0] mem_rdata;

  cit_point_mem #(
    .DW (16),
    .AW (9)
  ) u_mem (
    .sys_clk   (sys_clk),
    .mem_we    (bus_mem_wr),
    .mem_re    (bus_mem_rd | e_mem_rd),
    .mem_addr  (mem_addr),
    .mem_wdata (avs_writedata[15:0]), // Whole 16-bit time
    .mem_rdata (mem_rdata)
  );

  // Register read mux; unmapped words read zero
  always @*
  begin
    reg_rdata = 32'h0000_0000;
    case (avs_address)
      `CIT_REG_CTRL:      reg_rdata = {16'h0000, ctrl_reg};
      `CIT_REG_MULT:      reg_rdata = {16'h0000, mult_reg};
      `CIT_REG_ADDER:     reg_rdata = {16'h0000, adder_reg};
      `CIT_REG_FLOOR:     reg_rdata = {16'h0000, min_response_floor_reg};
      `CIT_REG_HCT_TIME:
        reg_rdata = {16'h0000, high_current_fixed_time_reg};
      `CIT_REG_HIGH_CURRENT_MULTIPLE_THRESHOLD:
        reg_rdata = {16'h0000, high_current_multiple_threshold_reg};
      `CIT_REG_BASE_CHAR: reg_rdata = {26'h0000000, base_char_reg};
      `CIT_REG_STATUS:
        reg_rdata = {29'h00000000, last_clamp_reg, resp_operate,
                     ~req_ready};
      `CIT_REG_LAST_TIME: reg_rdata = last_time_reg;
      default:            reg_rdata = 32'h0000_0000;
    endcase
  end

  // Merge the low two byte lanes into a 16-bit setting
  function [15:0] cit_be16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      cit_be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Avalon slave: one acknowledge cycle with waitrequest low
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bs_reg          <= BS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      case (bs_reg)
        BS_IDLE:
        begin
          if (bus_mem_rd)
          begin
            bs_reg <= BS_MEMRD; // Point read issued this cycle
          end
          else if (bus_req)
          begin
            avs_readdata    <= bus_pt ? 32'h0000_0000 : reg_rdata;
            avs_waitrequest <= 1'b0;
            bs_reg          <= BS_ACK;
          end
        end
        BS_MEMRD:
        begin
          avs_readdata    <= {16'h0000, mem_rdata};
          avs_waitrequest <= 1'b0;
          bs_reg          <= BS_ACK;
        end
        BS_ACK:
        begin
          avs_waitrequest <= 1'b1; // Writes commit on this edge
          bs_reg          <= BS_IDLE;
        end
        default:
        begin
          avs_waitrequest <= 1'b1;
          bs_reg          <= BS_IDLE;
        end
      endcase
    end
  end

  // Settings writes at the acknowledge edge
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg                            <= `CIT_ZERO16;
      mult_reg                            <= `CIT_MULT_RST;
      adder_reg                           <= `CIT_ZERO16;
      min_response_floor_reg              <= `CIT_ZERO16;
      high_current_fixed_time_reg         <= `CIT_ZERO16;
      high_current_multiple_threshold_reg <= `CIT_ZERO16;
      base_char_reg                       <= 6'h00;
    end
    else if (reg_wr)
    begin
      case (avs_address)
        `CIT_REG_CTRL:
          ctrl_reg <= cit_be16(ctrl_reg, avs_writedata, avs_byteenable);
        `CIT_REG_MULT:
          mult_reg <= cit_be16(mult_reg, avs_writedata, avs_byteenable);
        `CIT_REG_ADDER:
          adder_reg <= cit_be16(adder_reg, avs_writedata, avs_byteenable);
        `CIT_REG_FLOOR:
          min_response_floor_reg <= cit_be16(min_response_floor_reg,
                                             avs_writedata, avs_byteenable);
        `CIT_REG_HCT_TIME:
          high_current_fixed_time_reg <= cit_be16(
            high_current_fixed_time_reg, avs_writedata, avs_byteenable);
        `CIT_REG_HIGH_CURRENT_MULTIPLE_THRESHOLD:
          high_current_multiple_threshold_reg <= cit_be16(
            high_current_multiple_threshold_reg, avs_writedata,
            avs_byteenable);
        `CIT_REG_BASE_CHAR:
        begin
          // Only the 41 defined characteristics are accepted
          if (avs_byteenable[0] && (avs_writedata[7:0] <
              {2'b00, `CIT_BASE_COUNT}))
            base_char_reg <= avs_writedata[5:0];
        end
        default:
        begin
          ctrl_reg <= ctrl_reg; // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // Shaping of the interpolated curve time
  reg  [31:0] prod;
  reg  [24:0] shaped;
  reg  [31:0] curve_ms;
  reg  [31:0] final_ms;
  wire        comp_on = ctrl_reg[`CIT_CTRL_COMP] & e_op &
                        (e_curve == ctrl_reg[`CIT_CTRL_CSEL_HI:
                                             `CIT_CTRL_CSEL_LO]);

  always @*
  begin
    prod     = {16'h0000, e_ct} * {16'h0000, mult_reg};
    shaped   = {1'b0, prod[31:`CIT_MULT_FRAC]}
               + {9'h000, adder_reg};
    curve_ms = comp_on ? {7'h00, shaped} : {16'h0000, e_ct};
    final_ms = curve_ms;
    // Floor and fixed time bypass multiplier and adder
    if (comp_on && ctrl_reg[`CIT_CTRL_FLOOR] &&
        curve_ms < {16'h0000, min_response_floor_reg})
      final_ms = {16'h0000, min_response_floor_reg};
    // Fixed time applied last so it wins over the floor
    if (comp_on && ctrl_reg[`CIT_CTRL_HCT] &&
        e_raw > high_current_multiple_threshold_reg)
      final_ms = {16'h0000, high_current_fixed_time_reg};
  end

  // Time engine: scan, read two points, divide, shape
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      es_reg         <= ES_IDLE;
      req_ready      <= 1'b1;
      resp_valid     <= 1'b0;
      resp_time      <= 32'h0000_0000;
      resp_operate   <= 1'b0;
      last_time_reg  <= 32'h0000_0000;
      last_clamp_reg <= 1'b0;
      e_curve <= 2'b00;
      e_raw   <= {MW{1'b0}};
      e_m     <= 12'h000;
      e_op    <= 1'b0;
      e_idx   <= 7'h00;
      e_t0    <= 16'h0000;
      e_q     <= 22'h000000;
      e_rem   <= 6'h00;
      e_den   <= 6'h00;
      e_neg   <= 1'b0;
      e_cnt   <= 5'h00;
      e_ct    <= {TW{1'b0}};
    end
    else
    begin
      resp_valid <= 1'b0;
      case (es_reg)
        ES_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            e_curve   <= req_curve;
            e_raw     <= req_multiple;
            e_idx     <= 7'h00;
            e_op      <= req_multiple >= `CIT_ONE_PU;
            // Clamp into the table; ends hold their time
            if (req_multiple < `CIT_ONE_PU)
            begin
              e_m <= (req_multiple[11:0] > `CIT_LAST_RESET_M) ?
                     `CIT_LAST_RESET_M : req_multiple[11:0];
              last_clamp_reg <= req_multiple[11:0] > `CIT_LAST_RESET_M;
            end
            else if (req_multiple < {4'h0, `CIT_FIRST_OPER})
            begin
              e_m <= `CIT_FIRST_OPER;
              last_clamp_reg <= 1'b1;
            end
            else if (req_multiple > {4'h0, `CIT_LAST_OPER_M})
            begin
              e_m <= `CIT_LAST_OPER_M;
              last_clamp_reg <= 1'b1;
            end
            else
            begin
              e_m <= req_multiple[11:0];
              last_clamp_reg <= 1'b0;
            end
            es_reg <= ES_SCAN;
          end
        end
        ES_SCAN:
        begin
          // Find the segment holding the multiple
          if (e_idx == e_last || e_m < m_hi)
          begin
            e_den  <= (m_hi - m_lo) == 12'h000 ? 6'h01
                      : m_hi[5:0] - m_lo[5:0];
            e_q    <= {16'h0000, e_m[5:0] - m_lo[5:0]};
            es_reg <= ES_RD0;
          end
          else
            e_idx <= e_idx + 7'h01;
        end
        ES_RD0:
        begin
          if (e_mem_rd)
            es_reg <= ES_RD1; // Lower point requested
        end
        ES_RD1:
        begin
          e_t0   <= mem_rdata;
          es_reg <= ES_RD2;
        end
        ES_RD2:
        begin
          if (e_mem_rd)
            es_reg <= ES_RD3; // Upper point requested
        end
        ES_RD3:
        begin
          // Numerator |t1-t0| * offset, sign kept apart
          e_neg  <= mem_rdata < e_t0;
          e_q    <= (mem_rdata < e_t0 ? {6'h00, e_t0 - mem_rdata}
                                      : {6'h00, mem_rdata - e_t0})
                    * {16'h0000, e_q[5:0]};
          e_rem  <= 6'h00;
          e_cnt  <= `CIT_DIV_STEPS;
          es_reg <= ES_DIV;
        end
        ES_DIV:
        begin
          // Restoring division by the segment width
          if (e_cnt == 5'h00)
          begin
            e_ct   <= e_neg ? e_t0 - e_q[15:0] : e_t0 + e_q[15:0];
            es_reg <= ES_OUT;
          end
          else
          begin
            if (trial >= {1'b0, e_den})
            begin
              e_rem <= trial[5:0] - e_den;
              e_q   <= {e_q[20:0], 1'b1};
            end
            else
            begin
              e_rem <= trial[5:0];
              e_q   <= {e_q[20:0], 1'b0};
            end
            e_cnt <= e_cnt - 5'h01;
          end
        end
        ES_OUT:
        begin
          resp_valid    <= 1'b1;
          resp_time     <= final_ms;
          resp_operate  <= e_op;
          last_time_reg <= final_ms;
          req_ready     <= 1'b1;
          es_reg        <= ES_IDLE;
        end
        default:
        begin
          req_ready <= 1'b1;
          es_reg    <= ES_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [tb/cit_curve_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checker: bus answer timing and time request handshake
module cit_curve_chk #(
  parameter MW = 16
) (
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic [9:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic          req_valid,
  input wire logic [MW-1:0] req_multiple,
  input wire logic          req_ready,
  input wire logic          resp_valid,
  input wire logic [31:0]   resp_time,
  input wire logic          resp_operate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [MW-1:0] held_mult; // Multiple taken with the last request
  // Keep the multiple of the request being served
  always @(posedge sys_clk)
  begin
    if (req_valid && req_ready)
      held_mult <= req_multiple;
  end
  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("waitrequest low for more than one cycle");
  property p_ack_cause;
    !avs_waitrequest |-> avs_read || avs_write;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("waitrequest low without a request");
  property p_ack_bound;
    $rose(avs_read || avs_write) |-> ##[1:8] !avs_waitrequest;
  endproperty
  a_ack_bound: assert property (p_ack_bound)
    else $error("bus request not answered in time");
  property p_pt_width;
    !avs_waitrequest && avs_read && avs_address[9]
      |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_pt_width: assert property (p_pt_width)
    else $error("point read wider than 16 bits");
  property p_take;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_take: assert property (p_take)
    else $error("engine still ready after taking a request");
  property p_answer;
    req_valid && req_ready |-> ##[20:300] resp_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer to a taken request");
  property p_pulse;
    resp_valid |=> !resp_valid && req_ready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer pulse longer than one cycle");
  property p_hold;
    !resp_valid |-> $stable(resp_time) && $stable(resp_operate);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer changed between pulses");
  property p_side;
    resp_valid |-> resp_operate == (held_mult >= 16'h0064);
  endproperty
  a_side: assert property (p_side)
    else $error("wrong characteristic used for the multiple");
endmodule
`default_nettype wire

// [tb/cit_prot_elem.sv]
`timescale 1ns/1ps
`default_nettype none
// Protection element model: asks for a time and waits for the answer
module cit_prot_elem (
  input  wire logic        sys_clk,
  input  wire logic        req_ready,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_time,
  input  wire logic        resp_operate,
  output var  logic        req_valid,
  output var  logic [1:0]  req_curve,
  output var  logic [15:0] req_multiple
);
  // Idle request lines at time zero
  initial
  begin
    req_valid = 1'b0;
    req_curve = 2'h0;
    req_multiple = 16'h0000;
  end
  // One request after dly idle cycles; r is {operate, time}, x on hang
  task automatic ask(input logic [1:0] c, input logic [15:0] m,
                     input int dly, output logic [32:0] r);
    int n;
    repeat (dly + 1) @(posedge sys_clk);
    req_valid <= 1'b1;
    req_curve <= c;
    req_multiple <= m;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    req_curve <= ~c; // Released qualifiers do not keep the old value
    req_multiple <= ~m;
    n = 0;
    while (resp_valid !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    r = (n < 400) ? {resp_operate, resp_time} : 'x;
  endtask
endmodule
`default_nettype wire

// [tb/cit_curve_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cit_map.vh"
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module cit_curve_top_bench;
  logic        sys_clk = 1'b0;           // 125 MHz clock
  logic        rst_n = 1'b0;             // Synchronous reset, active low
  logic [9:0]  avs_address = 10'h000;    // Bus word address
  logic        avs_read = 1'b0;          // Bus read strobe
  logic        avs_write = 1'b0;         // Bus write strobe
  logic [31:0] avs_writedata = 32'h0;    // Bus write data
  logic [3:0]  avs_byteenable = 4'h3;    // Registers use the low lanes
  wire  logic [31:0] avs_readdata;       // Bus read data
  wire  logic        avs_waitrequest;    // Bus answer, low acknowledges
  wire  logic        req_valid;          // Time request
  wire  logic [1:0]  req_curve;          // Curve asked for
  wire  logic [15:0] req_multiple;       // Multiple in hundredths
  wire  logic        req_ready;          // Engine idle
  wire  logic        resp_valid;         // Answer pulse
  wire  logic [31:0] resp_time;          // Answer in ms
  wire  logic        resp_operate;       // Operate side used
  int          err_count = 0;            // Mismatches
  int          num_checks = 0;           // Comparisons made
  cit_curve_top i_cit_curve_top (.sys_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .req_valid, .req_curve, .req_multiple, .req_ready,
    .resp_valid, .resp_time, .resp_operate);
  cit_prot_elem i_cit_prot_elem (.sys_clk, .req_ready, .resp_valid,
    .resp_time, .resp_operate, .req_valid, .req_curve, .req_multiple);
  // Clock generator
  always #4 sys_clk = ~sys_clk;
  // Point time loaded at index j of curve c; 0.98 and 1.03 match
  function automatic logic [15:0] pt(input int c, input int j);
    if (j < 40)
      return 16'h0e1a + 16'h000a * j + 16'h0064 * c;
    return 16'h0fa0 - 16'h0028 * (j - 40) + 16'h0064 * c;
  endfunction
  // Straight line between two points, truncated toward the first
  function automatic logic [31:0] lerp(input int t0, input int t1,
                                       input int dm, input int span);
    return t0 + (t1 - t0) * dm / span;
  endfunction
  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      err_count++;
  endtask
  // Register or point write
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Register or point read
  task automatic rd(input logic [9:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Reset values at the ports and in the settings
  task automatic t_reset();
    logic [31:0] q;
    `CHK({req_ready, resp_valid, resp_time}, 34'h200000000)
    for (int a = 0; a < 9; a++)
    begin
      rd(a[9:0], q);
      `CHK(q, (a == 1) ? 32'h00000100 : 32'h0)
    end
  endtask
  // Base selection limit and an unmapped place
  task automatic t_regs();
    logic [31:0] q;
    wr(`CIT_REG_BASE_CHAR, 32'h00000028);
    wr(`CIT_REG_BASE_CHAR, 32'h00000029);
    rd(`CIT_REG_BASE_CHAR, q);
    `CHK(q, 32'h00000028)
    rd(10'h00f, q);
    `CHK(q, 32'h0)
  endtask
  // Load all four curves, then full scale and refused index
  task automatic t_load();
    logic [31:0] q;
    for (int c = 0; c < 4; c++)
      for (int j = 0; j < 120; j++)
        wr({1'b1, c[1:0], j[6:0]}, {16'h0, pt(c, j)});
    wr({3'h4, 7'h77}, 32'h0000ffff);
    rd({3'h4, 7'h77}, q);
    `CHK(q, 32'h0000ffff)
    rd({3'h5, 7'h2d}, q);
    `CHK(q, {16'h0, pt(1, 45)})
    rd({3'h4, 7'h78}, q);
    `CHK(q, 32'h0)
    // Low lane only: point write refused, setting merged by lane
    avs_byteenable <= 4'h1;
    wr({3'h4, 7'h00}, 32'h0);
    wr(`CIT_REG_ADDER, 32'h00001234);
    avs_byteenable <= 4'h3;
    rd({3'h4, 7'h00}, q);
    `CHK(q, {16'h0, pt(0, 0)})
    rd(`CIT_REG_ADDER, q);
    `CHK(q, 32'h00000034)
  endtask
  // Interpolation, clamps and hold beyond the last point
  task automatic t_interp();
    logic [32:0] r;
    logic [31:0] q;
    for (int c = 0; c < 4; c++)
    begin
      i_cit_prot_elem.ask(c[1:0], 16'h009d, c, r);
      `CHK(r, {1'b1, lerp(pt(c, 46), pt(c, 47), 7, 10)})
    end
    i_cit_prot_elem.ask(2'h0, 16'h0033, 0, r);
    `CHK(r, {1'b0, lerp(pt(0, 11), pt(0, 12), 1, 2)})
    i_cit_prot_elem.ask(2'h0, 16'h0063, 0, r);
    `CHK(r, {1'b0, 16'h0, pt(0, 39)})
    i_cit_prot_elem.ask(2'h0, 16'h0068, 0, r);
    `CHK(r, {1'b1, lerp(pt(0, 40), pt(0, 41), 1, 2)})
    i_cit_prot_elem.ask(2'h0, 16'h09c4, 2, r);
    `CHK(r, {1'b1, 32'h0000ffff})
    // Status: idle, operate side, clamped; last time kept
    rd(`CIT_REG_STATUS, q);
    `CHK(q, 32'h00000006)
    rd(`CIT_REG_LAST_TIME, q);
    `CHK(q, 32'h0000ffff)
  endtask
  // Composite shaping: scale, offset, floor and high-current time
  task automatic t_comp();
    logic [32:0] r;
    wr(`CIT_REG_MULT, 32'h00000200);
    wr(`CIT_REG_ADDER, 32'h00000005);
    wr(`CIT_REG_CTRL, 32'h00000001);
    i_cit_prot_elem.ask(2'h0, 16'h009d, 0, r);
    `CHK(r, {1'b1, 32'h2*lerp(pt(0,46), pt(0,47), 7, 10)+32'h5})
    i_cit_prot_elem.ask(2'h1, 16'h009d, 0, r);
    `CHK(r, {1'b1, lerp(pt(1, 46), pt(1, 47), 7, 10)})
    wr(`CIT_REG_FLOOR, 32'h00001f40);
    wr(`CIT_REG_CTRL, 32'h00000003);
    i_cit_prot_elem.ask(2'h0, 16'h009d, 0, r);
    `CHK(r, {1'b1, 32'h00001f40})
    i_cit_prot_elem.ask(2'h0, 16'h0064, 0, r);
    `CHK(r, {1'b1, 32'h2 * pt(0, 40) + 32'h5})
    wr(`CIT_REG_HCT_TIME, 32'h0000001e);
    wr(`CIT_REG_HIGH_CURRENT_MULTIPLE_THRESHOLD, 32'h00000320);
    wr(`CIT_REG_CTRL, 32'h00000007);
    i_cit_prot_elem.ask(2'h0, 16'h0321, 0, r);
    `CHK(r, {1'b1, 32'h0000001e})
    i_cit_prot_elem.ask(2'h0, 16'h0320, 0, r);
    `CHK(r, {1'b1, 32'h00001f40})
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_load();
    t_interp();
    t_comp();
    give_verdict();
  end
  // Watchdog, about ten times the expected run
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
bind cit_curve_top cit_curve_chk #(.MW(MW)) i_cit_curve_chk (.sys_clk,
  .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .req_valid, .req_multiple, .req_ready, .resp_valid,
  .resp_time, .resp_operate);
`default_nettype wire
